/* hdl/spfm_avalon_slave.v */
// spfm_avalon_slave.v: Avalon-MM slave handshake with one wait state
// assumes: master holds request until waitrequest is seen low
`timescale 1ns/100ps
module spfm_avalon_slave (
	// clock and reset
	input wire clk_sys,
	input wire reset,
	// bus request
	input wire read,
	input wire write,
	// handshake
	output wire waitrequest,
	output wire accept
);
	reg wait_reg;
	wire wait_next;
	// idle high so the output is a flop, low for the completing cycle
	assign wait_next = ~((read | write) & wait_reg);
	always @(posedge clk_sys) begin
		if (reset) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= wait_next;
		end
	end
	// request completes on the second edge it is held
	assign accept = (read | write) & ~wait_reg;
	assign waitrequest = wait_reg;
endmodule // spfm_avalon_slave

/* hdl/spfm_map.vh */
// spfm_map.vh: register offsets, field positions and reset values
// assumes: included by the pin mux design files, Avalon-MM word offsets
`ifndef SPFM_MAP_VH
`define SPFM_MAP_VH
// register index = word offset / 4, low two bits select the page: 32 pins, or 16 pins for the owner fields
`define SPFM_REG_SEL 4'h0
`define SPFM_REG_DRIVE 4'h1
`define SPFM_REG_SLEW 4'h2
`define SPFM_REG_PULL 4'h3
`define SPFM_REG_PININ 4'h4
`define SPFM_REG_PINOE 4'h5
`define SPFM_REG_OWNER 4'h6
`define SPFM_REG_ID 4'h7
// owner fields: two bits per pin
`define SPFM_OWN_PORT 2'h0
`define SPFM_OWN_ALT1 2'h1
`define SPFM_OWN_ALT2 2'h2
`define SPFM_OWN_W 2
// reset values: low drive, slew limit off, pull-ups off
`define SPFM_RST_BIT 1'h0
`define SPFM_ID_VALUE 32'h00005A17
`define SPFM_PIN_COUNT 51
`define SPFM_PAGE_PINS 16
`endif

/* hdl/spfm_pin_mux.v */
// spfm_pin_mux.v: shared pin function multiplexer with pad configuration
// assumes: Avalon-MM master on clk_sys, pads outside resolve the wire
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "spfm_map.vh"
module spfm_pin_mux #(
	parameter PINS = `SPFM_PIN_COUNT,
	parameter [31:0] ID_VALUE = `SPFM_ID_VALUE // arbitrary value
) (
	// clock and reset
	input wire clk_sys,
	input wire reset,
	// Avalon-MM slave
	input wire [5:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	// function enables from peripherals
	input wire [PINS-1:0] portEn,
	input wire [PINS-1:0] alt1En,
	input wire [PINS-1:0] alt2En,
	// function outputs
	input wire [PINS-1:0] portOut,
	input wire [PINS-1:0] portOe,
	input wire [PINS-1:0] alt1Out,
	input wire [PINS-1:0] alt1Oe,
	input wire [PINS-1:0] alt2Out,
	input wire [PINS-1:0] alt2Oe,
	// idle input levels
	input wire [PINS-1:0] portIdle,
	input wire [PINS-1:0] alt1Idle,
	input wire [PINS-1:0] alt2Idle,
	// routed inputs to functions
	output reg [PINS-1:0] portIn,
	output reg [PINS-1:0] alt1In,
	output reg [PINS-1:0] alt2In,
	// pads
	input wire [PINS-1:0] padIn,
	output reg [PINS-1:0] padOut,
	output reg [PINS-1:0] padOe,
	output reg [PINS-1:0] padDriveHigh,
	output reg [PINS-1:0] padSlewLimit,
	output reg [PINS-1:0] padPullUp
);
	localparam PAGES = (PINS + 31) / 32;
	localparam OPAGES = (PINS + 15) / 16;
	localparam PW = PAGES * 32;
	localparam OW = OPAGES * 32;

	// pad input synchroniser
	reg [PINS-1:0] padMeta_reg;
	reg [PINS-1:0] padSync_reg;
	// configuration
	reg [PW-1:0] drive_reg;
	reg [PW-1:0] slew_reg;
	reg [PW-1:0] pull_reg;
	wire [PINS-1:0] padOutC;
	wire [PINS-1:0] padOeC;
	wire [PINS-1:0] portInC;
	wire [PINS-1:0] alt1InC;
	wire [PINS-1:0] alt2InC;
	wire [OW-1:0] ownerAll;
	wire [PW-1:0] inAll;
	wire [PW-1:0] oeAll;
	wire accept;
	wire [3:0] regIdx;
	wire [1:0] page;
	wire [31:0] mask;
	reg [31:0] rdNext;
	integer k;

	assign regIdx = address[5:2];
	assign page = address[1:0];
	assign mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	assign inAll = {{(PW-PINS){1'b0}}, padSync_reg};
	assign oeAll = {{(PW-PINS){1'b0}}, padOe};

	spfm_avalon_slave uBus (
		.clk_sys(clk_sys),
		.reset(reset),
		.read(read),
		.write(write),
		.waitrequest(waitrequest),
		.accept(accept)
	);

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1) begin : gPin
			spfm_pin_slice uSlice (
				.portEn(portEn[g]),
				.alt1En(alt1En[g]),
				.alt2En(alt2En[g]),
				.portOut(portOut[g]),
				.portOe(portOe[g]),
				.alt1Out(alt1Out[g]),
				.alt1Oe(alt1Oe[g]),
				.alt2Out(alt2Out[g]),
				.alt2Oe(alt2Oe[g]),
				.portIdle(portIdle[g]),
				.alt1Idle(alt1Idle[g]),
				.alt2Idle(alt2Idle[g]),
				.padIn(padSync_reg[g]),
				.padOut(padOutC[g]),
				.padOe(padOeC[g]),
				.portIn(portInC[g]),
				.alt1In(alt1InC[g]),
				.alt2In(alt2InC[g]),
				.owner(ownerAll[2*g+1:2*g])
			);
		end
		if (OW > 2 * PINS) begin : gPad
			assign ownerAll[OW-1:2*PINS] = {(OW-2*PINS){1'b0}};
		end
	endgenerate

	// two flops before pad levels reach any logic
	always @(posedge clk_sys) begin
		if (reset) begin
			padMeta_reg <= {PINS{1'b0}};
			padSync_reg <= {PINS{1'b0}};
		end else begin
			padMeta_reg <= padIn;
			padSync_reg <= padMeta_reg;
		end
	end

	// configuration writes, one 32-pin page per word
	always @(posedge clk_sys) begin
		if (reset) begin
			drive_reg <= {PW{`SPFM_RST_BIT}};
			slew_reg <= {PW{`SPFM_RST_BIT}};
			pull_reg <= {PW{`SPFM_RST_BIT}};
		end else if (accept && write && page < PAGES) begin
			for (k = 0; k < 32; k = k + 1) begin
				if (mask[k]) begin
					case (regIdx)
					`SPFM_REG_DRIVE: begin
						drive_reg[page*32+k] <= writedata[k];
					end
					`SPFM_REG_SLEW: begin
						slew_reg[page*32+k] <= writedata[k];
					end
					`SPFM_REG_PULL: begin
						pull_reg[page*32+k] <= writedata[k];
					end
					default: begin
					end
					endcase
				end
			end
		end
	end

	// read mux; unmapped words read zero
	always @* begin
		rdNext = 32'h00000000;
		case (regIdx)
		`SPFM_REG_DRIVE: begin
			if (page < PAGES) rdNext = drive_reg[page*32 +: 32];
		end
		`SPFM_REG_SLEW: begin
			if (page < PAGES) rdNext = slew_reg[page*32 +: 32];
		end
		`SPFM_REG_PULL: begin
			if (page < PAGES) rdNext = pull_reg[page*32 +: 32];
		end
		`SPFM_REG_PININ: begin
			if (page < PAGES) rdNext = inAll[page*32 +: 32];
		end
		`SPFM_REG_PINOE: begin
			if (page < PAGES) rdNext = oeAll[page*32 +: 32];
		end
		`SPFM_REG_OWNER: begin
			if (page < OPAGES) rdNext = ownerAll[page*32 +: 32];
		end
		`SPFM_REG_ID: begin
			if (page == 2'h0) rdNext = ID_VALUE;
		end
		default: begin
			rdNext = 32'h00000000;
		end
		endcase
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			readdata <= 32'h00000000;
		end else if (read && !accept) begin
			readdata <= rdNext;
		end
	end

	// registered pad and function outputs
	always @(posedge clk_sys) begin
		if (reset) begin
			padOut <= {PINS{1'b0}};
			padOe <= {PINS{1'b0}};
			padDriveHigh <= {PINS{1'b0}};
			padSlewLimit <= {PINS{1'b0}};
			padPullUp <= {PINS{1'b0}};
			portIn <= {PINS{1'b0}};
			alt1In <= {PINS{1'b0}};
			alt2In <= {PINS{1'b0}};
		end else begin
			padOut <= padOutC;
			padOe <= padOeC;
			// drive and slew act while output, pull-up while input
			padDriveHigh <= drive_reg[PINS-1:0] & padOeC;
			padSlewLimit <= slew_reg[PINS-1:0] & padOeC;
			padPullUp <= pull_reg[PINS-1:0] & ~padOeC;
			portIn <= portInC;
			alt1In <= alt1InC;
			alt2In <= alt2InC;
		end
	end
endmodule // spfm_pin_mux

/* hdl/spfm_pin_slice.v */
// spfm_pin_slice.v: one pin's ownership decision and signal routing
// assumes: enables and data come from logic on clk_sys, no pin input
`timescale 1ns/100ps
`include "spfm_map.vh"
module spfm_pin_slice (
	// function enables
	input wire portEn,
	input wire alt1En,
	input wire alt2En,
	// function outputs
	input wire portOut,
	input wire portOe,
	input wire alt1Out,
	input wire alt1Oe,
	input wire alt2Out,
	input wire alt2Oe,
	// idle input levels of each function
	input wire portIdle,
	input wire alt1Idle,
	input wire alt2Idle,
	// synchronised pad level
	input wire padIn,
	// routed results
	output reg padOut,
	output reg padOe,
	output reg portIn,
	output reg alt1In,
	output reg alt2In,
	output reg [1:0] owner
);
	always @* begin
		padOut = 1'b0;
		padOe = 1'b0;
		portIn = portIdle;
		alt1In = alt1Idle;
		alt2In = alt2Idle;
		owner = `SPFM_OWN_PORT;
		// alt2 above alt1 above port
		if (alt2En) begin
			owner = `SPFM_OWN_ALT2;
			padOut = alt2Out;
			padOe = alt2Oe;
			alt2In = padIn;
		end else if (alt1En) begin
			owner = `SPFM_OWN_ALT1;
			padOut = alt1Out;
			padOe = alt1Oe;
			alt1In = padIn;
		end else begin
			// port owns when no alternate is enabled
			padOut = portOut;
			padOe = portOe & portEn;
			portIn = padIn;
		end
		// switching ownership steps a lower input to idle level
	end
endmodule // spfm_pin_slice

/* testbench/shared_pin_function_mux_tb_top.sv */
// shared_pin_function_mux_tb_top.sv: directed bench for the pin mux
// assumes: spfm_pin_mux, spfm_pad_model and the checker compiled first
`timescale 1ns/100ps
`include "spfm_map.vh"
module shared_pin_function_mux_tb_top;
	logic clk_sys = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
	logic [5:0] address = 6'h00;
	logic [31:0] writedata = 32'h00000000, rdv;
	logic [50:0] portEn = '0, alt1En = '0, alt2En = '0, portOut = '0;
	logic [50:0] portOe = '0, alt1Out = '0, alt1Oe = '0, alt2Out = '0;
	logic [50:0] alt2Oe = '0, portIdle = '1, alt1Idle = '1, alt2Idle = '1;
	logic [50:0] boardEn = '0, boardVal = '0;
	logic [3:0] byteenable = 4'hF;
	wire [31:0] readdata;
	wire waitrequest;
	wire [50:0] portIn, alt1In, alt2In, padIn, padOut, padOe;
	wire [50:0] padDriveHigh, padSlewLimit, padPullUp;
	int bad_count = 0, check_count = 0;
	spfm_pin_mux spfm_pin_mux_i (.*);
	spfm_pad_model spfm_pad_model_i (.*);
	initial forever #50 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [50:0] exp, logic [50:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(logic rd, logic [3:0] idx, logic [1:0] pg,
		logic [31:0] d);
		@(posedge clk_sys);
		read <= rd;
		write <= !rd;
		address <= {idx, pg};
		writedata <= d;
		// hold until waitrequest is sampled low at a rising edge
		do begin
			@(posedge clk_sys);
		end while (waitrequest !== 1'b0);
		rdv = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic settle;
		repeat (6) @(negedge clk_sys);
	endtask
	task automatic t_reset;
		chk("padOe", '0, padOe);
		chk("padPullUp", '0, padPullUp);
		bus(1, `SPFM_REG_PULL, 2'h0, 0);
		chk("pull", '0, rdv);
		bus(0, `SPFM_REG_ID, 2'h0, 32'h00000000);
		bus(1, `SPFM_REG_ID, 2'h0, 0);
		chk("id", `SPFM_ID_VALUE, rdv);
		bus(0, 4'h0, 2'h0, 32'hFFFFFFFF);
		bus(1, 4'h0, 2'h0, 0);
		chk("unmapped", '0, rdv);
		byteenable <= 4'h2;
		bus(0, `SPFM_REG_PULL, 2'h1, 32'hFFFFFFFF);
		byteenable <= 4'hF;
		bus(1, `SPFM_REG_PULL, 2'h1, 0);
		chk("pull lanes", 32'h0000FF00, rdv);
	endtask
	task automatic t_prio;
		int m;
		bus(0, `SPFM_REG_DRIVE, 2'h0, 32'hFFFFFFFF);
		bus(0, `SPFM_REG_SLEW, 2'h0, 32'h00000008);
		bus(1, `SPFM_REG_DRIVE, 2'h0, 0);
		chk("drive reg", 32'hFFFFFFFF, rdv);
		bus(1, `SPFM_REG_SLEW, 2'h0, 0);
		chk("slew reg", 32'h00000008, rdv);
		@(posedge clk_sys);
		{alt1Oe[3], alt2Oe[3], portOe[3], alt2Out[3]} <= 4'hF;
		for (m = 0; m < 8; m++) begin
			@(posedge clk_sys);
			{alt2En[3], alt1En[3], portEn[3]} <= 3'h0;
			@(posedge clk_sys);
			{alt2En[3], alt1En[3], portEn[3]} <= m[2:0];
			settle();
			chk("padOe", m != 0, padOe[3]);
			if (m != 0) chk("padOut", m[2], padOut[3]);
			chk("drive", m != 0, padDriveHigh[3]);
			chk("slew", m != 0, padSlewLimit[3]);
			chk("alt1In", m[2] | !m[1], alt1In[3]);
			bus(1, `SPFM_REG_OWNER, 2'h0, 0);
			chk("owner", m[2] ? 2'h2 : {1'b0, m[1]}, rdv[7:6]);
		end
	endtask
	task automatic t_pull;
		@(posedge clk_sys);
		{alt2En[3], alt1En[3], portEn[3], portOe[3]} <= 4'h0;
		bus(0, `SPFM_REG_PULL, 2'h0, 32'h00000008);
		settle();
		chk("pull", 1, padPullUp[3]);
		chk("portIn", 1, portIn[3]);
		@(posedge clk_sys);
		boardEn[3] <= 1'b1;
		settle();
		chk("portIn", 0, portIn[3]);
		bus(1, `SPFM_REG_PININ, 2'h0, 0);
		chk("pin in", 0, rdv[3]);
		@(posedge clk_sys);
		boardEn[3] <= 1'b0;
		alt2En[3] <= 1'b1;
		settle();
		chk("pull", 0, padPullUp[3]);
		@(posedge clk_sys);
		alt2Oe[3] <= 1'b0;
		boardEn[3] <= 1'b1;
		settle();
		chk("alt2In", 0, alt2In[3]);
		chk("portIn", 1, portIn[3]);
		chk("pull", 1, padPullUp[3]);
	endtask
	task automatic t_wide;
		@(posedge clk_sys);
		{alt1En[50], alt1Oe[50], alt1Out[50]} <= 3'h7;
		settle();
		chk("padOe", 1, padOe[50]);
		chk("padOut", 1, padOut[50]);
		bus(1, `SPFM_REG_OWNER, 2'h3, 0);
		chk("owner", 2'h1, rdv[5:4]);
		bus(1, `SPFM_REG_PINOE, 2'h1, 0);
		chk("pin oe", 1, rdv[18]);
	endtask
	task automatic print_verdict;
		if (bad_count == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_prio();
		t_pull();
		t_wide();
		print_verdict();
	end
	initial begin
		#1000000;
		bad_count++;
		print_verdict();
	end
endmodule // shared_pin_function_mux_tb_top

/* testbench/spfm_asserts.sv */
// spfm_asserts.sv: timing and routing checks on the pin mux ports
// assumes: bound to spfm_pin_mux, single clock domain
`timescale 1ns/100ps
module spfm_asserts #(parameter PINS = 51) (
	// clock, reset and bus
	input wire clk_sys, reset, read, write, waitrequest,
	input wire [31:0] readdata,
	// pin side
	input wire [PINS-1:0] portEn, alt1En, alt2En, portOut, portOe,
	input wire [PINS-1:0] alt1Out, alt1Oe, alt2Out, alt2Oe, alt1Idle,
	input wire [PINS-1:0] portIdle, alt1In, portIn, padOut, padOe,
	input wire [PINS-1:0] padDriveHigh, padSlewLimit, padPullUp
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	wire [PINS-1:0] oeWant = alt2En & alt2Oe | ~alt2En & alt1En & alt1Oe
		| ~alt2En & ~alt1En & portEn & portOe;
	wire [PINS-1:0] outWant = alt2En & alt2Out
		| ~alt2En & alt1En & alt1Out | ~alt2En & ~alt1En & portOut;
	wire [PINS-1:0] altOn = alt1En | alt2En;
	sequence reqFirst;
		(read || write) && !$past(read || write);
	endsequence
	AST_RESET: assert property (disable iff (1'b0) reset |=>
		padOe == '0 && padPullUp == '0 && readdata == '0)
		else $error("pins not idle after reset");
	AST_ONE_WAIT: assert property (reqFirst |-> waitrequest ##1 !waitrequest)
		else $error("bus wait state count wrong");
	AST_RD_HOLD: assert property (!read |=> $stable(readdata))
		else $error("readdata changed without a read");
	AST_OE: assert property (!$past(reset) |-> padOe == $past(oeWant))
		else $error("pad enable not from owner");
	AST_OUT: assert property (!$past(reset) |->
		(padOut & padOe) == ($past(outWant) & padOe))
		else $error("pad value not from owner");
	AST_ALT_IDLE: assert property (!$past(reset) |->
		(alt1In & $past(alt2En)) == ($past(alt1Idle) & $past(alt2En)))
		else $error("alt1 input not idle");
	AST_PORT_IDLE: assert property (!$past(reset) |->
		(portIn & $past(altOn)) == ($past(portIdle) & $past(altOn)))
		else $error("port input not idle");
	AST_PULL: assert property ((padPullUp & padOe) == '0)
		else $error("pull-up on a driven pin");
	AST_DRIVE: assert property ((padDriveHigh & ~padOe) == '0)
		else $error("drive strength on an input");
	AST_SLEW: assert property ((padSlewLimit & ~padOe) == '0)
		else $error("slew limit on an input");
endmodule // spfm_asserts
bind spfm_pin_mux spfm_asserts #(.PINS(PINS)) spfm_asserts_i (.*);

/* testbench/spfm_pad_model.sv */
// spfm_pad_model.sv: board side of the pads, resolves each pin level
// assumes: pads come from spfm_pin_mux, board drive set by the bench
`timescale 1ns/100ps
module spfm_pad_model #(parameter PINS = 51) (
	// clock
	input wire clk_sys,
	// from the pin mux
	input wire [PINS-1:0] padOut, padOe, padPullUp,
	// board drive
	input wire [PINS-1:0] boardEn, boardVal,
	// resolved level
	output wire [PINS-1:0] padIn
);
	reg [PINS-1:0] floatReg = '0;
	// a floating pin wanders every cycle
	always @(posedge clk_sys) floatReg <= ~floatReg;
	assign padIn = padOe & padOut | ~padOe & (boardEn & boardVal
		| ~boardEn & (padPullUp | floatReg));
endmodule // spfm_pad_model
